// ---- cia_pkg.sv ----
// package: register map, field positions and reset values for the interrupt dispatch block
package cia_pkg;
  localparam logic [7:0]  CIA_OFS_OPTION     = 8'h81;
  localparam logic [7:0]  CIA_OFS_PCHI       = 8'h8A;
  localparam logic [7:0]  CIA_OFS_IRQCTL     = 8'h8B;
  localparam logic [7:0]  CIA_OFS_PERIPH_IRQ_ENABLE_ONE       = 8'h8C;
  localparam logic [7:0]  CIA_OFS_PERIPH_IRQ_ENABLE_TWO       = 8'h8D;
  localparam logic [7:0]  CIA_BANK_MASK      = 8'h7F;
  localparam logic [7:0]  CIA_RST_OPTION     = 8'hFF;
  localparam logic [7:0]  CIA_RST_PCHI       = 8'h00;
  localparam logic [7:0]  CIA_RST_IRQCTL     = 8'h00;
  localparam logic [7:0]  CIA_RST_PERIPH_IRQ_ENABLE_ONE       = 8'h00;
  localparam logic [7:0]  CIA_RST_PERIPH_IRQ_ENABLE_TWO       = 8'h00;
  localparam logic [7:0]  CIA_PCHI_MASK      = 8'h1F;
  localparam logic [7:0]  CIA_PERIPH_IRQ_ENABLE_TWO_MASK      = 8'h01;
  localparam int          CIA_BIT_EDGE_SEL   = 6;
  localparam int          CIA_BIT_GIE        = 7;
  localparam int          CIA_BIT_PERIPHERAL_GROUP_ENABLE       = 6;
  localparam int          CIA_BIT_T0IE       = 5;
  localparam int          CIA_BIT_EXTIE      = 4;
  localparam int          CIA_BIT_PORTIE     = 3;
  localparam int          CIA_BIT_T0IF       = 2;
  localparam int          CIA_BIT_EXTIF      = 1;
  localparam int          CIA_BIT_PORTIF     = 0;
  localparam logic [12:0] CIA_VECTOR         = 13'h0004;
  typedef enum logic [1:0] {CIA_RUN, CIA_ASLEEP, CIA_POSTWAKE} cia_state_t;
endpackage : cia_pkg

// ---- cia_irq_wake.sv ----
// interrupt dispatch, sleep wake-up and program-counter high latch for an 8-bit core
`timescale 1ns/1ps
`default_nettype none
module cia_irq_wake
  import cia_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // data-memory register port from the core
  input  wire logic [8:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_HIT,
  // interrupt sources
  input  wire logic        EXT_PIN,
  input  wire logic        TMR0_EVENT,
  input  wire logic        PORT_CHANGE_EVENT,
  input  wire logic [7:0]  PERIPH_FLAGS_ONE,
  input  wire logic [7:0]  PERIPH_FLAGS_TWO,
  input  wire logic [7:0]  PERIPH_ASYNC_ONE,
  input  wire logic [7:0]  PERIPH_ASYNC_TWO,
  // sequencer handshake
  input  wire logic        SLEEP_ENTER,
  input  wire logic        INSTR_DONE,
  input  wire logic        PC_WRITE,
  input  wire logic [12:0] RETURN_PC,
  output logic             ASLEEP,
  output logic             WAKE,
  output logic             VECTOR_TAKE,
  output logic      [12:0] VECTOR_PC,
  output logic             STACK_PUSH,
  output logic      [12:0] STACK_DATA,
  output logic      [4:0]  PC_HIGH
);

  logic [7:0]  option_q;
  logic [7:0]  pchi_q;
  logic [7:0]  irqctl_q;
  logic [7:0]  periph_irq_enable_one_q;
  logic [7:0]  periph_irq_enable_two_q;
  logic        pin_q;
  cia_state_t  state_q;
  logic [7:0]  frozen_en1_q;
  logic [7:0]  frozen_en2_q;
  logic        frozen_ext_q;
  logic        vector_q;
  logic [12:0] vec_pc_q;
  logic        push_q;
  logic [12:0] push_data_q;

  // bank-independent decode: low seven bits only, so every bank hits
  logic [7:0] addr_b;
  logic       sel_opt;
  logic       sel_pchi;
  logic       sel_ictl;
  logic       sel_periph_irq_enable_one;
  logic       sel_periph_irq_enable_two;
  assign addr_b   = REG_ADDR[7:0] & CIA_BANK_MASK;
  assign sel_opt  = addr_b == (CIA_OFS_OPTION & CIA_BANK_MASK);
  assign sel_pchi = addr_b == (CIA_OFS_PCHI & CIA_BANK_MASK);
  assign sel_ictl = addr_b == (CIA_OFS_IRQCTL & CIA_BANK_MASK);
  assign sel_periph_irq_enable_one = addr_b == (CIA_OFS_PERIPH_IRQ_ENABLE_ONE & CIA_BANK_MASK);
  assign sel_periph_irq_enable_two = addr_b == (CIA_OFS_PERIPH_IRQ_ENABLE_TWO & CIA_BANK_MASK);

  // edge detection on the pin, polarity chosen by the edge-select bit
  logic rise;
  logic fall;
  logic ext_edge;
  assign rise     = EXT_PIN & ~pin_q;
  assign fall     = ~EXT_PIN & pin_q;
  assign ext_edge = option_q[CIA_BIT_EDGE_SEL] ? rise : fall;

  // pending requests
  logic periph_pend;
  logic core_pend;
  logic irq_pend;
  logic wake_src;
  assign periph_pend = |(PERIPH_FLAGS_ONE & periph_irq_enable_one_q) | |(PERIPH_FLAGS_TWO & periph_irq_enable_two_q);
  assign core_pend   = (irqctl_q[CIA_BIT_EXTIF] & irqctl_q[CIA_BIT_EXTIE])
                     | (irqctl_q[CIA_BIT_T0IF] & irqctl_q[CIA_BIT_T0IE])
                     | (irqctl_q[CIA_BIT_PORTIF] & irqctl_q[CIA_BIT_PORTIE]);
  assign irq_pend    = irqctl_q[CIA_BIT_GIE]
                     & (core_pend | (irqctl_q[CIA_BIT_PERIPHERAL_GROUP_ENABLE] & periph_pend));
  // only sources that run without a clock, with enables frozen at sleep entry
  assign wake_src    = |(PERIPH_FLAGS_ONE & PERIPH_ASYNC_ONE & frozen_en1_q)
                     | |(PERIPH_FLAGS_TWO & PERIPH_ASYNC_TWO & frozen_en2_q)
                     | (irqctl_q[CIA_BIT_EXTIF] & frozen_ext_q);

  logic take;
  assign take = (state_q == CIA_RUN) & INSTR_DONE & irq_pend & ~vector_q;

  // pin history register
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      // start from the pin level itself, so an idle-high pin gives no false edge
      pin_q <= EXT_PIN;
    end else begin
      pin_q <= EXT_PIN;
    end
  end

  // option and enable registers
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      option_q <= CIA_RST_OPTION;
      periph_irq_enable_one_q   <= CIA_RST_PERIPH_IRQ_ENABLE_ONE;
      periph_irq_enable_two_q   <= CIA_RST_PERIPH_IRQ_ENABLE_TWO;
    end else if (REG_WR) begin
      if (sel_opt) option_q <= REG_WDATA;
      if (sel_periph_irq_enable_one) periph_irq_enable_one_q <= REG_WDATA;
      if (sel_periph_irq_enable_two) periph_irq_enable_two_q <= REG_WDATA & CIA_PERIPH_IRQ_ENABLE_TWO_MASK;
    end
  end

  // high-byte latch: written only by software, never by vectoring
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pchi_q <= CIA_RST_PCHI;
    end else if (REG_WR && sel_pchi) begin
      pchi_q <= REG_WDATA & CIA_PCHI_MASK;
    end
  end
  // latch contents drive the counter top continuously; PC_WRITE is not used
  assign PC_HIGH = pchi_q[4:0];

  // control register; hardware flag sets win over a same-cycle software clear
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irqctl_q <= CIA_RST_IRQCTL;
    end else begin
      logic [7:0] nxt;
      nxt = irqctl_q;
      if (REG_WR && sel_ictl) nxt = REG_WDATA;
      if (ext_edge) nxt[CIA_BIT_EXTIF] = 1'b1;
      if (TMR0_EVENT) nxt[CIA_BIT_T0IF] = 1'b1;
      if (PORT_CHANGE_EVENT) nxt[CIA_BIT_PORTIF] = 1'b1;
      if (take) nxt[CIA_BIT_GIE] = 1'b0;  // keep nested entry out until return
      irqctl_q <= nxt;
    end
  end

  // sleep sequencing: asleep until a wake source, then one instruction runs
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_q      <= CIA_RUN;
      frozen_en1_q <= 8'h00;
      frozen_en2_q <= 8'h00;
      frozen_ext_q <= 1'b0;
    end else begin
      unique case (state_q)
        CIA_RUN: begin
          if (SLEEP_ENTER) begin
            state_q      <= CIA_ASLEEP;
            frozen_en1_q <= periph_irq_enable_one_q;
            frozen_en2_q <= periph_irq_enable_two_q;
            frozen_ext_q <= irqctl_q[CIA_BIT_EXTIE];
          end
        end
        CIA_ASLEEP: begin
          if (wake_src) state_q <= CIA_POSTWAKE;
        end
        CIA_POSTWAKE: begin
          if (INSTR_DONE) state_q <= CIA_RUN;
        end
      endcase
    end
  end
  assign ASLEEP = state_q == CIA_ASLEEP;
  assign WAKE   = (state_q == CIA_ASLEEP) & wake_src;

  // vectoring: fixed address, only the return address stacked
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      vector_q    <= 1'b0;
      vec_pc_q    <= 13'h0000;
      push_q      <= 1'b0;
      push_data_q <= 13'h0000;
    end else begin
      vector_q <= take;
      push_q   <= take;
      if (take) begin
        vec_pc_q    <= CIA_VECTOR;
        push_data_q <= RETURN_PC;
      end
    end
  end
  assign VECTOR_TAKE = vector_q;
  assign VECTOR_PC   = vec_pc_q;
  assign STACK_PUSH  = push_q;
  assign STACK_DATA  = push_data_q;

  // register read mux; unmapped addresses give no hit and zero data
  always_comb begin
    REG_RDATA = 8'h00;
    REG_HIT   = 1'b1;
    if (sel_opt) REG_RDATA = option_q;
    else if (sel_pchi) REG_RDATA = pchi_q;
    else if (sel_ictl) REG_RDATA = irqctl_q;
    else if (sel_periph_irq_enable_one) REG_RDATA = periph_irq_enable_one_q;
    else if (sel_periph_irq_enable_two) REG_RDATA = periph_irq_enable_two_q;
    else REG_HIT = 1'b0;
    if (!REG_RD) REG_RDATA = 8'h00;
  end

  AST_EDGE_SETS_FLAG: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ext_edge |=> irqctl_q[CIA_BIT_EXTIF]) else $error("edge did not set pin flag");
  AST_VECTOR_ADDR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    VECTOR_TAKE |-> VECTOR_PC == CIA_VECTOR) else $error("wrong vector address");
  AST_NEEDS_GIE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    VECTOR_TAKE |-> $past(irqctl_q[CIA_BIT_GIE])) else $error("vector without global enable");
  AST_PUSH_WITH_VEC: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    STACK_PUSH == VECTOR_TAKE) else $error("push not paired with vector");
  AST_LATCH_KEPT: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    take && !REG_WR |=> $stable(pchi_q)) else $error("latch changed on vector");
  AST_WAKE_SOURCE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ASLEEP && !wake_src |=> ASLEEP) else $error("woke without source");
  sequence s_wake;
    ASLEEP && wake_src ##1 state_q == CIA_POSTWAKE;
  endsequence
  AST_POST_WAKE_NO_VEC: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_wake |=> !VECTOR_TAKE) else $error("vectored before post-sleep instruction");
  AST_SLEEP_ENTRY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state_q == CIA_RUN && SLEEP_ENTER |=> ASLEEP) else $error("sleep not entered");

  // named steps used by the properties below
  sequence s_take;
    take;
  endsequence
  sequence s_sleep_entry;
    state_q == CIA_RUN && SLEEP_ENTER;
  endsequence
  sequence s_postwake_step;
    state_q == CIA_POSTWAKE && INSTR_DONE;
  endsequence
  sequence s_postwake_wait;
    state_q == CIA_POSTWAKE && !INSTR_DONE;
  endsequence

  // the stacked word is the return address offered at the taking edge
  AST_PUSH_RETURN_PC: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_take |=> STACK_DATA == $past(RETURN_PC)) else $error("stacked word is not the return pc");

  // every take shows up one cycle later as a vector to the fixed entry
  AST_TAKE_LOADS_VECTOR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_take |=> VECTOR_TAKE && VECTOR_PC == CIA_VECTOR) else $error("take did not vector");

  // global enable drops on entry, so a second request cannot nest before return
  AST_TAKE_CLEARS_GIE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_take |=> !irqctl_q[CIA_BIT_GIE]) else $error("global enable left set after take");

  // with no other source pending, a take needs the pin flag and its enable
  AST_PIN_NEEDS_ENABLES: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_take && !(irqctl_q[CIA_BIT_T0IF] && irqctl_q[CIA_BIT_T0IE])
      && !(irqctl_q[CIA_BIT_PORTIF] && irqctl_q[CIA_BIT_PORTIE]) && !periph_pend
      |-> irqctl_q[CIA_BIT_EXTIE] && irqctl_q[CIA_BIT_EXTIF])
    else $error("pin request vectored while disabled");

  // an accepted edge always matches the polarity chosen by the edge select
  AST_EDGE_POLARITY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ext_edge |-> EXT_PIN == option_q[CIA_BIT_EDGE_SEL]) else $error("edge of wrong polarity");

  // enables are captured on the sleep edge; later writes cannot widen wake-up
  AST_ENABLES_FROZEN: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_sleep_entry |=> frozen_en1_q == $past(periph_irq_enable_one_q) && frozen_en2_q == $past(periph_irq_enable_two_q)
      && frozen_ext_q == $past(irqctl_q[CIA_BIT_EXTIE]))
    else $error("wake enables not captured at sleep entry");

  // the wake strobe belongs to the sleeping state only
  AST_WAKE_ONLY_ASLEEP: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !ASLEEP |-> !WAKE) else $error("wake strobe while running");

  // after wake-up the block waits for the post-sleep instruction to finish
  AST_HOLD_POSTWAKE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_postwake_wait |=> state_q == CIA_POSTWAKE) else $error("left wake state too early");

  // the post-sleep instruction ends with the core back in run and no vector yet
  AST_ONE_INSTR_AFTER_WAKE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_postwake_step |=> state_q == CIA_RUN && !VECTOR_TAKE)
    else $error("post-sleep instruction not completed before vector");

  // without global enable the core just carries on after the sleep point
  AST_NO_BRANCH_NO_GIE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state_q == CIA_RUN && !irqctl_q[CIA_BIT_GIE] |=> !VECTOR_TAKE)
    else $error("vectored with global enable clear");

  // the latch reads back through the mirrored decode in any bank
  AST_LATCH_MIRROR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    REG_RD && sel_pchi |-> REG_RDATA == pchi_q && REG_HIT) else $error("latch not mirrored");

  // the counter top only ever sees the latch contents
  AST_LATCH_TO_TOP: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    PC_HIGH == pchi_q[4:0]) else $error("counter top bits not from latch");

endmodule : cia_irq_wake
`default_nettype wire

// ---- cia_core_model.sv ----
// core sequencer model: gives instruction boundaries, records vector and push pulses
`timescale 1ns/1ps
`default_nettype none
module cia_core_model (
  input  wire logic        clk,
  input  wire logic        vector_take,
  input  wire logic        stack_push,
  input  wire logic [12:0] stack_data,
  input  wire logic [12:0] vector_pc,
  output logic             instr_done,
  output logic      [12:0] return_pc
);
  int          takes = 0;
  int          lone  = 0;
  logic [12:0] pushed;
  logic [12:0] vpc;
  initial begin
    instr_done = 1'b0;
    return_pc  = 13'h0000;
  end
  // a take is only sound when push and vector land in the same cycle
  always @(posedge clk) begin
    if (vector_take && stack_push) begin
      takes++;
      pushed = stack_data;
      vpc    = vector_pc;
    end else if (vector_take || stack_push) begin
      lone++;
    end
  end
  // one instruction boundary, driven off the sampling edge
  task automatic step(input logic [12:0] pc);
    @(negedge clk);
    instr_done = 1'b1;
    return_pc  = pc;
    @(negedge clk);
    instr_done = 1'b0;
  endtask
endmodule // cia_core_model
`default_nettype wire

// ---- cia_irq_wake_test.sv ----
// self-checking bench for the interrupt dispatch and wake block
`timescale 1ns/1ps
`default_nettype none
module cia_irq_wake_test;
  import cia_pkg::*;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, ext_pin, sleep_enter;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, pflags;
  logic        reg_hit, asleep, wake, vtake, spush, idone;
  logic [12:0] vpc, sdata, rpc;
  logic [4:0]  pc_high;
  logic [7:0]  zero8 = 8'h00;
  logic        tmr0_ev;
  logic [7:0]  pasync;
  int          failures = 0;
  int          n_compared = 0;
  cia_irq_wake cia_irq_wake_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .REG_HIT(reg_hit), .EXT_PIN(ext_pin), .TMR0_EVENT(tmr0_ev), .PORT_CHANGE_EVENT(1'b0),
    .PERIPH_FLAGS_ONE(pflags), .PERIPH_FLAGS_TWO(zero8), .PERIPH_ASYNC_ONE(pasync),
    .PERIPH_ASYNC_TWO(zero8), .SLEEP_ENTER(sleep_enter), .INSTR_DONE(idone),
    .PC_WRITE(1'b0), .RETURN_PC(rpc), .ASLEEP(asleep), .WAKE(wake), .VECTOR_TAKE(vtake),
    .VECTOR_PC(vpc), .STACK_PUSH(spush), .STACK_DATA(sdata), .PC_HIGH(pc_high));
  cia_core_model cia_core_model_i (.clk(ref_clk), .vector_take(vtake), .stack_push(spush),
    .stack_data(sdata), .vector_pc(vpc), .instr_done(idone), .return_pc(rpc));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp, input logic hit);
    @(negedge ref_clk);
    reg_addr = a; reg_rd = 1'b1;
    #1 check("rdata", {5'h00, reg_rdata}, {5'h00, exp});
    check("hit", {12'h000, reg_hit}, {12'h000, hit});
    reg_rd = 1'b0;
  endtask
  // pin level change, then four cycles for the edge detect to set the flag
  task automatic pin(input logic v);
    @(negedge ref_clk);
    ext_pin = v;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic t_reset_map();
    rd(9'h081, CIA_RST_OPTION, 1'b1); rd(9'h08A, CIA_RST_PCHI, 1'b1);
    rd(9'h10B, CIA_RST_IRQCTL, 1'b1); rd(9'h18C, CIA_RST_PERIPH_IRQ_ENABLE_ONE, 1'b1);
    rd(9'h08D, CIA_RST_PERIPH_IRQ_ENABLE_TWO, 1'b1); rd(9'h097, 8'h00, 1'b0);
    wr(9'h00A, 8'h35); rd(9'h18A, 8'h15, 1'b1);
  endtask
  task automatic t_edges();
    pin(1'b1); rd(9'h08B, 8'h02, 1'b1);
    wr(9'h08B, 8'h00); wr(9'h081, 8'hBF); pin(1'b0); rd(9'h08B, 8'h02, 1'b1);
    wr(9'h08B, 8'h00); pin(1'b1); rd(9'h08B, 8'h00, 1'b1);
    pin(1'b0); wr(9'h08B, 8'h80); cia_core_model_i.step(13'h0100);
    check("no take", 13'(cia_core_model_i.takes), 13'h0000);
  endtask
  task automatic t_vector();
    wr(9'h08B, 8'h90); pin(1'b1); pin(1'b0);
    cia_core_model_i.step(13'h0123); repeat (2) @(negedge ref_clk);
    check("takes", 13'(cia_core_model_i.takes), 13'h0001);
    check("lone", 13'(cia_core_model_i.lone), 13'h0000);
    check("pushed", cia_core_model_i.pushed, 13'h0123);
    check("vpc", cia_core_model_i.vpc, CIA_VECTOR);
    check("pchi", {8'h00, pc_high}, 13'h0015);
    rd(9'h08A, 8'h15, 1'b1); rd(9'h08B, 8'h12, 1'b1);
  endtask
  // timer flag with its enable but no global enable: flag stands, no vector
  task automatic t_events();
    wr(9'h08B, 8'h20);
    @(negedge ref_clk); tmr0_ev = 1'b1;
    @(negedge ref_clk); tmr0_ev = 1'b0;
    rd(9'h08B, 8'h24, 1'b1);
    cia_core_model_i.step(13'h0150); repeat (2) @(negedge ref_clk);
    check("gated", 13'(cia_core_model_i.takes), 13'h0001);
  endtask
  // a clockless peripheral whose enable was set before sleep wakes the core
  task automatic t_async();
    wr(9'h08B, 8'h00); wr(9'h08C, 8'h02); pasync = 8'h02;
    @(negedge ref_clk); sleep_enter = 1'b1;
    @(negedge ref_clk); sleep_enter = 1'b0;
    pflags = 8'h02;
    #1 check("async wake", {12'h000, wake}, 13'h0001);
    @(negedge ref_clk);
    check("awake", {12'h000, asleep}, 13'h0000);
    pflags = 8'h00; cia_core_model_i.step(13'h0300); repeat (2) @(negedge ref_clk);
    check("no branch", 13'(cia_core_model_i.takes), 13'h0002);
  endtask
  // sleep, refuse a clocked source, wake on the pin; ie sets the irqctl value
  task automatic t_sleep(input logic [7:0] ie, input int exp_takes);
    wr(9'h08B, ie); wr(9'h08C, 8'h01);
    @(negedge ref_clk); sleep_enter = 1'b1;
    @(negedge ref_clk); sleep_enter = 1'b0;
    #1 check("asleep", {12'h000, asleep}, 13'h0001);
    @(negedge ref_clk); pflags = 8'h01; repeat (3) @(negedge ref_clk);
    check("stay", {12'h000, asleep}, 13'h0001);
    pflags = 8'h00; pin(1'b1); pin(1'b0);
    check("woke", {12'h000, asleep}, 13'h0000);
    cia_core_model_i.step(13'h0200); repeat (2) @(negedge ref_clk);
    check("after", 13'(cia_core_model_i.takes), 13'h0001);
    cia_core_model_i.step(13'h0201); repeat (2) @(negedge ref_clk);
    check("branch", 13'(cia_core_model_i.takes), 13'(exp_takes));
  endtask
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; ext_pin = 1'b0; sleep_enter = 1'b0;
    reg_addr = 9'h000; reg_wdata = 8'h00; pflags = 8'h00;
    tmr0_ev = 1'b0; pasync = 8'h00;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset_map();
    t_edges();
    t_vector();
    t_events();
    t_sleep(8'h10, 1);
    t_sleep(8'h90, 2);
    t_async();
    wrap_up();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #40000;
    failures++;
    wrap_up();
  end
endmodule // cia_irq_wake_test
`default_nettype wire
